// file: rcfg_device.sv
// Processor end: captures boot mode, takes configuration from defaults,
// the expansion pins or a serial memory, and decodes it.
// Assumes board logic drives boot mode and config word while reset output is low.
`timescale 1ns/100ps
// Behaviour
// - Sample boot mode at reset output rise
// - Mode 00 uses built-in defaults only
// - Mode 10 uses expansion pins during reset
// - Board buffers switch word during reset
// - Bus mode codes 1xx decode
// - Bus mode codes 0xx decode
// - Bit five selects limp or PLL
// - PCI modes: bit four host/agent
// - Non-PCI modes: bit four oscillator bypass
// - PCI modes: bit three slew rate
// - Non-PCI multiplier from three bits
// - PCI multiplier from two bits
// - Flash boot needs PCI muxed 8-bit
// - Mode 11 loads from serial memory
// - Configuration follows received serial data
// - Speed select needs jumper absent, capability, enable
// - Generator 33/66 MHz from speed select
// - Any 33 MHz card clears capability
// - Speed enable bit resets cleared
// - Generator reprogramming lost at power-on
// - USB clock output disabled by default
module rcfg_device (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Processor internal reset request, low holds reset output asserted
    input wire logic core_reset_req_n_i,
    // Carrier to the board
    rcfg_if.dev link,
    // Decoded configuration
    output rcfg_pkg::rcfg_cfg_t cfg_o,
    output logic [1:0] boot_mode_o,
    output logic cfg_done_o
);
    // Synchronised external inputs
    logic [1:0] bm_s1_ff, bm_s2_ff;
    logic [7:0] ad_s1_ff, ad_s2_ff;
    logic di_s1_ff, di_s2_ff;
    logic rst_out_n_ff;           // Reset output register
    logic rst_out_prev_ff;        // Previous value for edge detection
    logic [1:0] boot_mode_ff;     // Captured boot mode
    logic [7:0] word_ff;          // Raw configuration word
    logic [7:0] ad_held_ff;       // Last pin value seen during reset
    logic done_ff;
    rcfg_pkg::rcfg_cfg_t cfg_ff;
    // Serial engine
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_CMD_ST = 2'b01,
        SER_DATA = 2'b10,
        SER_END = 2'b11
    } rcfg_ser_t;
    rcfg_ser_t ser_st_ff;
    logic [1:0] div_ff;
    logic sck_ff, cs_n_ff, do_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] cmd_sh_ff;
    logic [7:0] rx_sh_ff;
    logic tick;
    logic rise;

    // Two-flop synchronisers on pins from the board
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bm_s1_ff <= 2'h0;
            bm_s2_ff <= 2'h0;
            ad_s1_ff <= 8'h00;
            ad_s2_ff <= 8'h00;
            di_s1_ff <= 1'b0;
            di_s2_ff <= 1'b0;
        end else begin
            bm_s1_ff <= link.boot_mode_pins;
            bm_s2_ff <= bm_s1_ff;
            ad_s1_ff <= link.expansion_addr_data;
            ad_s2_ff <= ad_s1_ff;
            di_s1_ff <= link.serial_boot_data_in;
            di_s2_ff <= di_s1_ff;
        end
    end

    // Reset output follows the internal request, one flop late
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_out_n_ff <= 1'b0;
            rst_out_prev_ff <= 1'b0;
        end else begin
            rst_out_n_ff <= core_reset_req_n_i;
            rst_out_prev_ff <= rst_out_n_ff;
        end
    end
    assign rise = rst_out_n_ff && !rst_out_prev_ff;

    // Track the word on the pins while reset output is low; the buffer is gone after
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ad_held_ff <= 8'h00;
        end else if (!rst_out_n_ff) begin
            ad_held_ff <= ad_s2_ff;
        end
    end

    // Boot mode capture and source choice at the reset output rise
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_mode_ff <= rcfg_pkg::BOOT_DEFAULT;
            word_ff <= rcfg_pkg::CFG_DEFAULT;
            done_ff <= 1'b0;
        end else if (!rst_out_n_ff) begin
            done_ff <= 1'b0;
        end else if (rise) begin
            boot_mode_ff <= bm_s2_ff;
            unique case (bm_s2_ff)
                rcfg_pkg::BOOT_PARALLEL: begin
                    word_ff <= ad_held_ff;
                    done_ff <= 1'b1;
                end
                rcfg_pkg::BOOT_SERIAL: begin
                    done_ff <= 1'b0;
                end
                default: begin
                    // Reserved code treated as defaults; pins ignored
                    word_ff <= rcfg_pkg::CFG_DEFAULT;
                    done_ff <= 1'b1;
                end
            endcase
        end else if (ser_st_ff == SER_END && !done_ff) begin
            word_ff <= rx_sh_ff;
            done_ff <= 1'b1;
        end else if (ser_st_ff == SER_DATA) begin
            word_ff <= rx_sh_ff;
        end
    end

    // Serial clock enable divider
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= (div_ff == rcfg_pkg::SER_DIV) ? 2'h0 : div_ff + 2'h1;
        end
    end
    assign tick = (div_ff == rcfg_pkg::SER_DIV);

    // Serial read: command byte then one configuration byte, mode 0
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ser_st_ff <= SER_IDLE;
            sck_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            do_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            cmd_sh_ff <= 8'h00;
            rx_sh_ff <= 8'h00;
        end else begin
            unique case (ser_st_ff)
                SER_IDLE: begin
                    if (rise && bm_s2_ff == rcfg_pkg::BOOT_SERIAL) begin
                        ser_st_ff <= SER_CMD_ST;
                        cs_n_ff <= 1'b0;
                        cmd_sh_ff <= {rcfg_pkg::SER_CMD[6:0], 1'b0};
                        do_ff <= rcfg_pkg::SER_CMD[7];
                        bit_cnt_ff <= 4'h0;
                        sck_ff <= 1'b0;
                    end
                end
                SER_CMD_ST: begin
                    if (tick) begin
                        sck_ff <= !sck_ff;
                        if (sck_ff) begin
                            // Falling edge: shift next command bit out
                            do_ff <= cmd_sh_ff[7];
                            cmd_sh_ff <= {cmd_sh_ff[6:0], 1'b0};
                            if (bit_cnt_ff == 4'h7) begin
                                ser_st_ff <= SER_DATA;
                                bit_cnt_ff <= 4'h0;
                            end else begin
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                end
                SER_DATA: begin
                    if (tick) begin
                        sck_ff <= !sck_ff;
                        if (!sck_ff) begin
                            // Rising edge: sample memory data, MSB first
                            rx_sh_ff <= {rx_sh_ff[6:0], di_s2_ff};
                        end else if (bit_cnt_ff == 4'(rcfg_pkg::SER_BITS - 1)) begin
                            ser_st_ff <= SER_END;
                            cs_n_ff <= 1'b1;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                SER_END: begin
                    // Hold until another reset restarts the sequence
                    sck_ff <= 1'b0;
                    if (!rst_out_n_ff) begin
                        ser_st_ff <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    // Decode the configuration word into named settings
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_ff <= '0;
        end else begin
            unique case (word_ff[rcfg_pkg::BUS_MODE_MSB:rcfg_pkg::BUS_MODE_LSB])
                3'h7: begin cfg_ff.pci_en <= 1'b1; cfg_ff.muxed <= 1'b1; cfg_ff.port_size <= rcfg_pkg::PORT_8; end
                3'h6: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b1; cfg_ff.port_size <= rcfg_pkg::PORT_16; end
                3'h5: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b1; cfg_ff.port_size <= rcfg_pkg::PORT_8; end
                3'h4: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b1; cfg_ff.port_size <= rcfg_pkg::PORT_32; end
                3'h3: begin cfg_ff.pci_en <= 1'b1; cfg_ff.muxed <= 1'b1; cfg_ff.port_size <= rcfg_pkg::PORT_16; end
                3'h2: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b0; cfg_ff.port_size <= rcfg_pkg::PORT_16; end
                3'h1: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b0; cfg_ff.port_size <= rcfg_pkg::PORT_8; end
                3'h0: begin cfg_ff.pci_en <= 1'b0; cfg_ff.muxed <= 1'b0; cfg_ff.port_size <= rcfg_pkg::PORT_32; end
            endcase
            cfg_ff.limp <= word_ff[rcfg_pkg::LIMP_BIT];
            // PCI vs non-PCI decides how bits 4:1 are read
            if (word_ff[6:5] == 2'h3) begin
                cfg_ff.pci_host <= word_ff[rcfg_pkg::HOST_OSC_BIT];
                cfg_ff.osc_bypass <= 1'b0;
                cfg_ff.slew_66 <= word_ff[rcfg_pkg::SLEW_BIT];
                unique case (word_ff[1:0])
                    2'h3: cfg_ff.vco_mult <= 5'd8;
                    2'h2: cfg_ff.vco_mult <= 5'd16;
                    2'h1: cfg_ff.vco_mult <= 5'd6;
                    2'h0: cfg_ff.vco_mult <= 5'd12;
                endcase
            end else begin
                cfg_ff.pci_host <= 1'b0;
                cfg_ff.osc_bypass <= word_ff[rcfg_pkg::HOST_OSC_BIT];
                cfg_ff.slew_66 <= 1'b0;
                unique case (word_ff[rcfg_pkg::MULT_MSB:rcfg_pkg::MULT_LSB])
                    3'h7: cfg_ff.vco_mult <= 5'd8;
                    3'h6: cfg_ff.vco_mult <= 5'd16;
                    3'h5: cfg_ff.vco_mult <= 5'd6;
                    3'h4: cfg_ff.vco_mult <= 5'd12;
                    3'h3: cfg_ff.vco_mult <= 5'd18;
                    3'h2: cfg_ff.vco_mult <= 5'd24;
                    3'h1: cfg_ff.vco_mult <= 5'd10;
                    3'h0: cfg_ff.vco_mult <= 5'd20;
                endcase
            end
        end
    end

    // Outputs straight from flops, expansion pin drive tied off; processor never drives the bus in this model
    assign cfg_o = cfg_ff;
    assign boot_mode_o = boot_mode_ff;
    assign cfg_done_o = done_ff;
    assign link.proc_reset_out_n = rst_out_n_ff;
    assign link.ead_dev_o = 8'h00;
    assign link.ead_dev_oe_n = 1'b1;
    assign link.serial_boot_clock = sck_ff;
    assign link.serial_boot_chip_select_n = cs_n_ff;
    assign link.serial_boot_data_out = do_ff;
endmodule : rcfg_device

// file: rcfg_pkg.sv
// Package for the reset-time configuration capture and clock speed select.
// Assumes a single 200 MHz clock domain on each end and active-low async reset.
package rcfg_pkg;
    // Boot mode codes on the two boot mode pins
    localparam logic [1:0] BOOT_DEFAULT = 2'h0;
    localparam logic [1:0] BOOT_RESERVED = 2'h1;
    localparam logic [1:0] BOOT_PARALLEL = 2'h2;
    localparam logic [1:0] BOOT_SERIAL = 2'h3;
    // Field positions within the configuration word (bit n-1 is switch position n)
    localparam int BUS_MODE_MSB = 7;
    localparam int BUS_MODE_LSB = 5;
    localparam int LIMP_BIT = 4;
    localparam int HOST_OSC_BIT = 3;
    localparam int SLEW_BIT = 2;
    localparam int MULT_MSB = 2;
    localparam int MULT_LSB = 0;
    // Reset configuration defaults: PCI muxed 8-bit, PLL on, host, 66 MHz slew, x6
    // Host needs bit 3 set, or the defaults would come up as a PCI agent
    localparam logic [7:0] CFG_DEFAULT = 8'hed;
    // Port size codes
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;
    localparam logic [1:0] PORT_32 = 2'h0;
    // Configuration word length loaded serially from the memory
    localparam int SER_BITS = 8;
    // Serial clock divider: 200 MHz / (2*4) = 25 MHz serial clock
    localparam logic [1:0] SER_DIV = 2'h3;
    // Serial read command byte sent before data
    localparam logic [7:0] SER_CMD = 8'h03;
    // Decoded configuration
    typedef struct packed {
        logic pci_en;
        logic muxed;
        logic [1:0] port_size;
        logic limp;
        logic pci_host;
        logic osc_bypass;
        logic slew_66;
        logic [4:0] vco_mult;
    } rcfg_cfg_t;
endpackage : rcfg_pkg

// file: rcfg_if.sv
// Interface joining the processor configuration end and the board logic end.
// Two-way address/data pins are modelled as in/out/enable; the level is resolved here.
`timescale 1ns/100ps
interface rcfg_if;
    logic proc_reset_out_n;       // Processor reset output, low while asserted
    logic [1:0] boot_mode_pins;   // Boot mode driven by board logic
    logic [7:0] ead_dev_o;        // Expansion addr/data driven by processor
    logic ead_dev_oe_n;           // Processor output enable, low drives
    logic [7:0] ead_brd_o;        // Expansion addr/data driven by board buffer
    logic ead_brd_oe_n;           // Board buffer enable, low drives
    logic [7:0] expansion_addr_data; // Resolved pin level
    logic serial_boot_data_in;    // Memory to processor
    logic serial_boot_data_out;   // Processor to memory
    logic serial_boot_chip_select_n; // Memory select, low active
    logic serial_boot_clock;      // Serial clock
    // Board buffer wins during reset; otherwise processor; otherwise pulled low
    assign expansion_addr_data = !ead_brd_oe_n ? ead_brd_o : (!ead_dev_oe_n ? ead_dev_o : 8'h00);
    modport dev (
        output proc_reset_out_n, ead_dev_o, ead_dev_oe_n,
        input boot_mode_pins, expansion_addr_data,
        input serial_boot_data_in,
        output serial_boot_data_out, serial_boot_chip_select_n, serial_boot_clock
    );
    modport brd (
        input proc_reset_out_n, expansion_addr_data,
        output boot_mode_pins, ead_brd_o, ead_brd_oe_n
    );
endinterface : rcfg_if

// file: rcfg_board.sv
// Board end: drives boot mode and the switch word during reset and
// selects the 33/66 MHz reference speed through a small register port.
// Assumes switches, jumper and capability line are slow asynchronous levels.
`timescale 1ns/100ps
module rcfg_board (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Carrier to the processor
    rcfg_if.brd link,
    // Switches and jumper
    input wire logic [1:0] mode_select_switch_i,
    input wire logic [7:0] config_word_switch_i,
    input wire logic speed_force_jumper_i,
    input wire logic pci_m66_capable_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Clock generator control
    output logic clock_speed_select_drive_o,
    output logic usb_clock_output_en_o
);
    localparam logic [3:0] PCI_CLK_CFG_ADDR = 4'h0;
    logic [1:0] sw_s1_ff, sw_s2_ff;
    logic [7:0] cw_s1_ff, cw_s2_ff;
    logic [2:0] misc_s1_ff, misc_s2_ff;
    logic rst_s1_ff, rst_s2_ff;
    logic spd_en_ff;
    logic s2_ff;
    logic oe_n_ff;
    logic [31:0] rdata_ff;

    // Two-flop synchronisers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_s1_ff <= 2'h0;
            sw_s2_ff <= 2'h0;
            cw_s1_ff <= 8'h00;
            cw_s2_ff <= 8'h00;
            misc_s1_ff <= 3'h0;
            misc_s2_ff <= 3'h0;
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            sw_s1_ff <= mode_select_switch_i;
            sw_s2_ff <= sw_s1_ff;
            cw_s1_ff <= config_word_switch_i;
            cw_s2_ff <= cw_s1_ff;
            misc_s1_ff <= {speed_force_jumper_i, pci_m66_capable_i, 1'b0};
            misc_s2_ff <= misc_s1_ff;
            rst_s1_ff <= link.proc_reset_out_n;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Buffer enabled only while reset output low, released afterwards
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= rst_s2_ff;
        end
    end

    // Speed enable register resets cleared; set wins nothing else here
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            spd_en_ff <= 1'b0;
        end else if (wr_i && addr_i == PCI_CLK_CFG_ADDR) begin
            spd_en_ff <= wdata_i[0];
        end
    end

    // 66 MHz only with jumper absent, all cards capable, enable set
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s2_ff <= 1'b0;
        end else begin
            s2_ff <= !misc_s2_ff[2] && misc_s2_ff[1] && spd_en_ff;
        end
    end

    // Read data in the cycle after the strobe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= 32'h0;
        end else if (rd_i && addr_i == PCI_CLK_CFG_ADDR) begin
            rdata_ff <= {28'h0, s2_ff, misc_s2_ff[1], misc_s2_ff[2], spd_en_ff};
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    assign link.boot_mode_pins = sw_s2_ff;
    assign link.ead_brd_o = cw_s2_ff;
    assign link.ead_brd_oe_n = oe_n_ff;
    assign rdata_o = rdata_ff;
    assign clock_speed_select_drive_o = s2_ff;
    assign usb_clock_output_en_o = 1'b0;
endmodule : rcfg_board

// file: rcfg_properties.sv
// Concurrent checks on the carrier between the processor end and the board end.
// Assumes one 200 MHz clock and an active-low asynchronous reset shared by both ends.
`timescale 1ns/100ps
module rcfg_properties (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Carrier signals
    input wire logic proc_reset_out_n,
    input wire logic [1:0] boot_mode_pins,
    input wire logic ead_dev_oe_n,
    input wire logic ead_brd_oe_n,
    input wire logic serial_boot_chip_select_n,
    input wire logic serial_boot_clock
);
    logic rst_ff; // Reset output one cycle back
    logic [1:0] mode_ff; // Boot mode seen at the last reset-output rise
    logic [7:0] cs_cnt_ff; // Cycles with the memory selected, saturating so it never wraps
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Capture the boot mode the way the processor should
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_ff <= 1'b0;
            mode_ff <= 2'h0;
        end else begin
            rst_ff <= proc_reset_out_n;
            if (proc_reset_out_n && !rst_ff) begin
                mode_ff <= boot_mode_pins;
            end
        end
    end
    // Length of the current serial frame
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_cnt_ff <= 8'h00;
        end else if (serial_boot_chip_select_n) begin
            cs_cnt_ff <= 8'h00;
        end else if (cs_cnt_ff != 8'hff) begin
            cs_cnt_ff <= cs_cnt_ff + 8'h01;
        end
    end
    a_no_pin_fight: assert property (!(!ead_brd_oe_n && !ead_dev_oe_n))
        else $error("both ends drive the expansion pins");
    a_dev_quiet_reset: assert property (!proc_reset_out_n |-> ead_dev_oe_n)
        else $error("processor drives expansion pins during reset");
    a_buf_on_reset: assert property (!proc_reset_out_n [*4] |-> !ead_brd_oe_n)
        else $error("board buffer off while reset output asserted");
    // The board sees the reset output through two flops plus the enable flop, so three cycles late
    a_buf_off_run: assert property (proc_reset_out_n [*4] |-> ead_brd_oe_n)
        else $error("board buffer still on after reset");
    a_mode_steady: assert property ($rose(proc_reset_out_n) |-> $stable(boot_mode_pins))
        else $error("boot mode moved at reset output rise");
    a_serial_only_m11: assert property ($fell(serial_boot_chip_select_n) |-> mode_ff == 2'h3)
        else $error("serial memory selected outside serial mode");
    a_serial_starts: assert property ($rose(proc_reset_out_n) && boot_mode_pins == 2'h3
        |-> ##[1:40] !serial_boot_chip_select_n) else $error("serial load did not start");
    a_serial_in_reset: assert property (!proc_reset_out_n |-> serial_boot_chip_select_n)
        else $error("serial memory selected during reset");
    a_idle_clock: assert property (serial_boot_chip_select_n && $past(serial_boot_chip_select_n)
        |-> $stable(serial_boot_clock)) else $error("serial clock runs outside a frame");
    a_frame_length: assert property ($rose(serial_boot_chip_select_n)
        |-> cs_cnt_ff >= 8'd120 && cs_cnt_ff <= 8'd160) else $error("serial frame length wrong");
    cover property ($rose(proc_reset_out_n) && boot_mode_pins == 2'h2);
    cover property ($rose(serial_boot_chip_select_n));
    cover property (!ead_brd_oe_n);
endmodule : rcfg_properties

// file: rcfg_bench.sv
// Testbench joining the processor end and the board end through the carrier.
// Assumes the design's package and interface are compiled first.
`timescale 1ns/100ps
module rcfg_bench;
    logic clock_i = 1'b0; // 200 MHz clock
    logic rstn_i = 1'b0; // Async reset, low active
    logic core_n = 1'b0; // Processor reset request
    logic [1:0] mode_sw = 2'h0; // Boot mode switch
    logic [7:0] cfg_sw = 8'h00; // Configuration word switch
    logic jumper = 1'b0, m66 = 1'b1; // Speed jumper and capability line
    logic [3:0] addr = 4'h0; // Register port
    logic [31:0] wdata = 32'h0, rdata, q;
    logic wr_s = 1'b0, rd_s = 1'b0;
    logic spd, usb_en, cfg_done;
    logic [1:0] boot_mode;
    rcfg_pkg::rcfg_cfg_t cfg;
    int fails = 0, compares = 0, cycles = 0, rises = 0;
    integer seed = 32'hf960417f;
    logic [7:0] ser_word = 8'h00, cmd_rx = 8'h00; // Serial memory content and command seen
    logic sclk_q = 1'b0;
    logic [4:0] mtab [8] = '{5'd20, 5'd10, 5'd24, 5'd18, 5'd12, 5'd6, 5'd16, 5'd8}; // Multiplier table
    rcfg_if link();
    rcfg_device rcfg_device_inst (.clock_i(clock_i), .rstn_i(rstn_i), .core_reset_req_n_i(core_n), .link(link),
        .cfg_o(cfg), .boot_mode_o(boot_mode), .cfg_done_o(cfg_done));
    rcfg_board rcfg_board_inst (.clock_i(clock_i), .rstn_i(rstn_i), .link(link), .mode_select_switch_i(mode_sw),
        .config_word_switch_i(cfg_sw), .speed_force_jumper_i(jumper), .pci_m66_capable_i(m66), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .clock_speed_select_drive_o(spd),
        .usb_clock_output_en_o(usb_en));
    rcfg_properties rcfg_properties_inst (.clock_i(clock_i), .rstn_i(rstn_i),
        .proc_reset_out_n(link.proc_reset_out_n), .boot_mode_pins(link.boot_mode_pins),
        .ead_dev_oe_n(link.ead_dev_oe_n), .ead_brd_oe_n(link.ead_brd_oe_n),
        .serial_boot_chip_select_n(link.serial_boot_chip_select_n), .serial_boot_clock(link.serial_boot_clock));
    always #2.5 clock_i = ~clock_i;
    // Serial memory: answers after the command byte; released data line toggles
    always @(posedge clock_i) begin
        sclk_q <= link.serial_boot_clock;
        if (link.serial_boot_chip_select_n !== 1'b0) begin
            rises <= 0;
            link.serial_boot_data_in <= ~link.serial_boot_data_in;
        end else if (link.serial_boot_clock && !sclk_q) begin
            rises <= rises + 1;
            if (rises < 8) cmd_rx <= {cmd_rx[6:0], link.serial_boot_data_out};
            if (rises >= 7 && rises < 15) link.serial_boot_data_in <= ser_word[14 - rises];
        end
    end
    // Hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails = fails + 1;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge clock_i);
        wr_s <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a; rd_s <= 1'b1;
        @(posedge clock_i);
        rd_s <= 1'b0;
        @(negedge clock_i);
        q = rdata;
    endtask : rd
    function automatic rcfg_pkg::rcfg_cfg_t expect_cfg(input logic [7:0] w);
        rcfg_pkg::rcfg_cfg_t c;
        logic [2:0] b;
        b = w[7:5];
        c = '0;
        c.pci_en = (b == 3'h7) || (b == 3'h3);
        c.muxed = b[2] || (b == 3'h3);
        c.port_size = (b == 3'h7 || b == 3'h5 || b == 3'h1) ? rcfg_pkg::PORT_8 :
            (b == 3'h4 || b == 3'h0) ? rcfg_pkg::PORT_32 : rcfg_pkg::PORT_16;
        c.limp = w[4];
        c.pci_host = w[3];
        c.osc_bypass = w[3];
        c.slew_66 = w[2];
        c.vco_mult = mtab[c.pci_en ? {1'b1, w[1:0]} : w[2:0]];
        return c;
    endfunction : expect_cfg
    // Compare only the fields that the selected bus mode gives meaning to
    task automatic cmp_cfg(input logic [7:0] w);
        rcfg_pkg::rcfg_cfg_t e;
        e = expect_cfg(w);
        check({cfg.pci_en, cfg.muxed, cfg.port_size}, {e.pci_en, e.muxed, e.port_size});
        check(cfg.limp, e.limp);
        if (e.pci_en) begin
            check(cfg.pci_host, e.pci_host);
            check(cfg.slew_66, e.slew_66);
        end else begin
            check(cfg.osc_bypass, e.osc_bypass);
        end
        check(cfg.vco_mult, e.vco_mult);
    endtask : cmp_cfg
    // One reset of the processor with the switches set meanwhile
    task automatic boot(input logic [1:0] m, input logic [7:0] w);
        int n;
        @(posedge clock_i);
        core_n <= 1'b0; mode_sw <= m; cfg_sw <= w;
        repeat (10) @(posedge clock_i);
        check(link.expansion_addr_data, w);
        check(cfg_done, 1'b0);
        core_n <= 1'b1;
        n = 0;
        while (cfg_done !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            n = n + 1;
        end
        repeat (2) @(posedge clock_i);
        check(cfg_done, 1'b1);
        check(boot_mode, m);
    endtask : boot
    initial begin
        logic [7:0] w;
        link.serial_boot_data_in = 1'b0;
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        // Speed enable resets cleared; unmapped write leaves it alone
        rd(4'h0);
        check(q[0], 1'b0);
        wr(4'h9, 32'h1);
        rd(4'h0);
        check({spd, q[0]}, 2'b00);
        check(usb_en, 1'b0);
        for (int i = 0; i < 8; i++) begin
            // Levels change just after a rising edge, never on the falling one
            @(posedge clock_i);
            jumper <= i[0];
            m66 <= i[1];
            wr(4'h0, {31'h0, i[2]});
            repeat (4) @(posedge clock_i);
            check(spd, !i[0] && i[1] && i[2]);
            rd(4'h0);
            check(q[3:0], {!i[0] && i[1] && i[2], i[1], i[0], i[2]});
        end
        // Parallel mode: every bus code, then random words
        for (int i = 0; i < 40; i++) begin
            w = $random(seed);
            if (i < 8) w[7:5] = i[2:0];
            boot(2'h2, w);
            cmp_cfg(w);
        end
        // Defaults ignore the pins: PCI muxed 8-bit, PLL, host, 66 MHz slew, x6
        for (int i = 0; i < 4; i++) begin
            boot(i[0] ? 2'h1 : 2'h0, $random(seed));
            cmp_cfg(8'hed);
        end
        // Serial mode: memory word differs from the switch word
        for (int i = 0; i < 4; i++) begin
            ser_word = $random(seed);
            boot(2'h3, ~ser_word);
            check(cmd_rx, rcfg_pkg::SER_CMD);
            cmp_cfg(ser_word);
        end
        results();
    end
endmodule : rcfg_bench
